// ===== hdl/hbdl_pkg.sv
package hbdl_pkg;

  // host side pins, sampled together
  typedef struct packed {
    logic       wr_n;   // host write strobe
    logic       cs_n;   // host chip select
    logic [3:0] addr;   // host address lines
    logic [7:0] data;   // host data bus
    logic       program_strobe;   // program_strobe
    logic [3:0] nib;    // nibble_bus_bit_3 .. nibble_bus_bit_0
  } hbdl_pins_t;

  // two-byte converter port
  typedef struct packed {
    logic        oe;    // bus buffer enable
    logic        cs_n;
    logic        wr_n;
    logic [11:0] data;
  } hbdl_word_t;

  // nibble-loaded converter port
  typedef struct packed {
    logic       oe;     // selector drives the converter
    logic       wr_n;
    logic [1:0] addr;   // low/middle/high nibble select
    logic [3:0] data;
  } hbdl_nib_t;

  // expander-port converters
  typedef struct packed {
    logic [3:0] sel_n;  // one select per converter
    logic [3:0] data;
  } hbdl_exp_t;

  localparam int         PIN_W        = $bits(hbdl_pins_t);
  localparam hbdl_pins_t PINS_RST     = '{wr_n: 1'b1, cs_n: 1'b1, addr: 4'h0,
                                          data: 8'h00, program_strobe: 1'b1, nib: 4'h0};
  localparam logic [3:0] ADDR_LO_BYTE = 4'h0;  // first byte of the two-byte word
  localparam logic [3:0] ADDR_HI_BYTE = 4'h1;  // second byte, loads the converter
  localparam logic [1:0] NIB_PAGE     = 2'h1;  // addr[3:2] for the nibble converter
  localparam logic [1:0] NIB_LO       = 2'h0;
  localparam logic [1:0] NIB_MID      = 2'h1;
  localparam logic [1:0] NIB_HI       = 2'h2;
  localparam logic [1:0] NIB_IDLE     = 2'h3;  // forced address when unselected
  localparam logic [1:0] OP_WRITE     = 2'h1;  // expander write operation code
  localparam logic [7:0] BYTE_RST     = 8'h00;
  localparam logic [3:0] CAP_RST      = 4'h0;
  localparam logic [3:0] SEL_NONE     = 4'hf;

endpackage : hbdl_pkg

// ===== hdl/hbdl_sync.sv
`timescale 1ns/1ps
// three-stage pin synchroniser; output moves only when stages 2 and 3 agree
module hbdl_sync import hbdl_pkg::*; #(
  parameter int                W    = 1,
  parameter logic [W-1:0]      INIT = '0
) (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] stable
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // s1 feeds only s2, to keep metastability out of the compare
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // per bit, so a slow bit does not hold back the others
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          stable[i] <= INIT[i];
        end else if (s2[i] == s3[i]) begin
          stable[i] <= s3[i];
        end
      end
    end
  endgenerate

endmodule : hbdl_sync

// ===== hdl/hbdl_loader.sv
`timescale 1ns/1ps
// How it works
// - buffer enabled only on converter address
// - first byte held, second forms word
// - converter takes low twelve bits
// - select and store gated by decode
// - strobe fall captures address and opcode
// - low bits address, high bits opcode
// - only write opcode enables select decoder
// - strobe rise stores nibble to decoded converter
// - two address lines pick nibble part
// - selector passes lower or upper half
// - low byte fills low and middle
// - converter inputs isolated unless addressed
// - address and store forced idle unselected
module hbdl_loader import hbdl_pkg::*; (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire hbdl_pins_t pins,
  output hbdl_word_t      word_port,
  output hbdl_nib_t       nib_port,
  output hbdl_exp_t       exp_port
);

  hbdl_pins_t p;       // settled pins
  hbdl_pins_t q;       // settled pins one cycle ago
  logic [7:0] first_byte;
  logic [3:0] cap;     // captured address and opcode

  // one filter for every pin: costs four cycles, but no glitch reaches a decode
  hbdl_sync #(
    .W    (PIN_W),
    .INIT (PINS_RST)
  ) u_sync (
    .mclk   (mclk),
    .nrst   (nrst),
    .pin    (pins),
    .stable (p)
  );

  // chip-select qualified address compare, used by several decodes
  function automatic logic hit(input hbdl_pins_t s, input logic [3:0] a);
    return !s.cs_n && (s.addr == a);
  endfunction : hit

  function automatic logic nib_hit(input hbdl_pins_t s);
    return !s.cs_n && (s.addr[3:2] == NIB_PAGE) && (s.addr[1:0] != NIB_IDLE);
  endfunction : nib_hit

  logic wr_rise;
  logic program_strobe_fall;
  logic program_strobe_rise;
  logic op_is_write;
  assign wr_rise     = p.wr_n && !q.wr_n;
  assign program_strobe_fall   = !p.program_strobe && q.program_strobe;
  assign program_strobe_rise   = p.program_strobe && !q.program_strobe;
  assign op_is_write = (cap[3:2] == OP_WRITE);

  // previous settled pins for edge detection
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      q <= PINS_RST;
    end else begin
      q <= p;
    end
  end

  // ---- two-byte variant
  // first byte held until the second write arrives
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      first_byte <= BYTE_RST;
    end else if (wr_rise && hit(q, ADDR_LO_BYTE)) begin
      first_byte <= q.data;
    end
  end

  // strobes and data follow the decode of the high-byte address, the buffer that of either byte address
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      word_port <= '{oe: 1'b0, cs_n: 1'b1, wr_n: 1'b1, data: 12'h000};
    end else begin
      word_port.oe   <= hit(p, ADDR_LO_BYTE) || hit(p, ADDR_HI_BYTE);
      word_port.cs_n <= !hit(p, ADDR_HI_BYTE);
      word_port.wr_n <= !(hit(p, ADDR_HI_BYTE) && !p.wr_n);
      // upper nibble of the second byte has no converter input and is dropped
      // converter latches on its own strobe rise, so data tracks the bus meanwhile
      if (hit(p, ADDR_HI_BYTE)) begin
        word_port.data <= {p.data[3:0], first_byte};
      end
    end
  end

  // ---- nibble-select variant
  // selector drives zero and idle address whenever not addressed
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      nib_port <= '{oe: 1'b0, wr_n: 1'b1, addr: NIB_IDLE, data: 4'h0};
    end else if (nib_hit(p)) begin
      nib_port.oe   <= 1'b1;
      nib_port.addr <= p.addr[1:0];
      nib_port.wr_n <= p.wr_n;
      // middle part comes from the upper half, no software shift needed
      nib_port.data <= (p.addr[1:0] == NIB_MID) ? p.data[7:4]
                                                : p.data[3:0];
    end else begin
      nib_port.oe   <= 1'b0;
      nib_port.addr <= NIB_IDLE;
      nib_port.wr_n <= 1'b1;
      nib_port.data <= 4'h0;
    end
  end

  // ---- expander-port variant
  // address/opcode nibble arrives before the strobe falls, data after
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cap <= CAP_RST;
    end else if (program_strobe_fall) begin
      cap <= q.nib;
    end
  end

  // select held low through the data phase; its rise with the strobe stores
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      exp_port <= '{sel_n: SEL_NONE, data: 4'h0};
    end else if (!p.program_strobe && !program_strobe_fall && op_is_write) begin
      exp_port.sel_n <= ~(4'h1 << cap[1:0]);
      exp_port.data  <= p.nib;
    end else begin
      exp_port.sel_n <= SEL_NONE;
    end
  end

  // ---- checks
  // checks sample settled pins, so each answer is looked for one edge later; opcode_refuse_a and opcode_split_a wait two after the fall
  sequence lo_write_s;
    wr_rise && hit(q, ADDR_LO_BYTE);
  endsequence
  sequence hi_write_s;
    !p.wr_n && hit(p, ADDR_HI_BYTE);
  endsequence
  sequence write_fall_s;
    program_strobe_fall && q.nib[3:2] == OP_WRITE;
  endsequence
  sequence other_fall_s;
    program_strobe_fall && q.nib[3:2] != OP_WRITE;
  endsequence

  buffer_enable_a: assert property (@(posedge mclk) disable iff (!nrst)
    word_port.oe |-> $past(hit(p, ADDR_LO_BYTE) || hit(p, ADDR_HI_BYTE)))
    else $error("bus buffer enabled off address");

  byte_join_a: assert property (@(posedge mclk) disable iff (!nrst)
    lo_write_s |=> first_byte == $past(q.data))
    else $error("first byte not held");

  right_justify_a: assert property (@(posedge mclk) disable iff (!nrst)
    hi_write_s |=> word_port.data == {$past(p.data[3:0]), first_byte})
    else $error("word not right justified");

  word_strobe_a: assert property (@(posedge mclk) disable iff (!nrst)
    !word_port.wr_n |-> !word_port.cs_n && $past(hit(p, ADDR_HI_BYTE)))
    else $error("store strobe outside decode");

  capture_fall_a: assert property (@(posedge mclk) disable iff (!nrst)
    program_strobe_fall |=> cap == $past(q.nib))
    else $error("nibble not captured on strobe fall");

  opcode_gate_a: assert property (@(posedge mclk) disable iff (!nrst)
    !op_is_write |=> exp_port.sel_n == SEL_NONE)
    else $error("converter selected without write opcode");

  store_rise_a: assert property (@(posedge mclk) disable iff (!nrst)
    (!p.program_strobe && op_is_write && !program_strobe_fall) ##1 program_strobe_rise
    |-> exp_port.sel_n == ~(4'h1 << cap[1:0]) ##1 exp_port.sel_n == SEL_NONE)
    else $error("decoded converter not stored on strobe rise");

  nibble_select_a: assert property (@(posedge mclk) disable iff (!nrst)
    (nib_hit(p) && p.addr[1:0] == NIB_MID) |=> nib_port.data == $past(p.data[7:4]))
    else $error("middle nibble not from upper half");

  nibble_isolate_a: assert property (@(posedge mclk) disable iff (!nrst)
    !nib_port.oe |-> nib_port.data == 4'h0)
    else $error("converter inputs not isolated");

  nibble_gate_a: assert property (@(posedge mclk) disable iff (!nrst)
    !nib_hit(p) |=> nib_port.addr == NIB_IDLE && nib_port.wr_n)
    else $error("address or store not forced idle");

  buffer_off_a: assert property (@(posedge mclk) disable iff (!nrst)
    !(hit(p, ADDR_LO_BYTE) || hit(p, ADDR_HI_BYTE)) |=> !word_port.oe)
    else $error("bus buffer left enabled");

  word_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    !hit(p, ADDR_HI_BYTE) |=> $stable(word_port.data))
    else $error("word changed outside high byte access");

  select_decode_a: assert property (@(posedge mclk) disable iff (!nrst)
    hit(p, ADDR_HI_BYTE) |=> !word_port.cs_n)
    else $error("converter not selected on its address");

  capture_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    !program_strobe_fall |=> $stable(cap))
    else $error("capture moved without strobe fall");

  opcode_split_a: assert property (@(posedge mclk) disable iff (!nrst)
    write_fall_s ##1 !p.program_strobe
    |=> !exp_port.sel_n[$past(q.nib[1:0], 2)] && $onehot(~exp_port.sel_n))
    else $error("select not from low capture bits");

  opcode_refuse_a: assert property (@(posedge mclk) disable iff (!nrst)
    other_fall_s |=> ##1 exp_port.sel_n == SEL_NONE)
    else $error("non-write opcode selected a converter");

  expander_data_a: assert property (@(posedge mclk) disable iff (!nrst)
    (!p.program_strobe && !program_strobe_fall && op_is_write) |=> exp_port.data == $past(p.nib))
    else $error("data nibble not presented");

  nibble_part_a: assert property (@(posedge mclk) disable iff (!nrst)
    nib_hit(p) |=> nib_port.oe && nib_port.addr == $past(p.addr[1:0]))
    else $error("nibble part address wrong");

  nibble_lower_a: assert property (@(posedge mclk) disable iff (!nrst)
    (nib_hit(p) && p.addr[1:0] != NIB_MID) |=> nib_port.data == $past(p.data[3:0]))
    else $error("low or high nibble not from lower half");

endmodule : hbdl_loader

// ===== bench/hbdl_host.sv
`timescale 1ns/1ps
// host bus model, all pins as one group
module hbdl_host import hbdl_pkg::*; (
  input  wire logic mclk,
  output hbdl_pins_t pins
);
  hbdl_pins_t p  = PINS_RST;
  logic [7:0] nz = 8'h5a;
  // released bus wanders, so a stale byte never passes
  always_ff @(posedge mclk) nz <= nz + 8'h3b;
  // data driven only while selected
  always_comb begin
    pins = p;
    if (p.cs_n) pins.data = nz;
  end
  // one step, held past the pin filter
  task put(input hbdl_pins_t v);
    @(posedge mclk);
    p <= v;
    repeat (8) @(posedge mclk);
    #1;
  endtask : put
  // select with data, then strobe low
  task wr_open(input logic [3:0] a, input logic [7:0] d);
    hbdl_pins_t v;
    v = p;
    v.addr = a;
    v.data = d;
    v.cs_n = 1'b0;
    put(v);
    v.wr_n = 1'b0;
    put(v);
  endtask : wr_open
  // strobe rise, then deselect; data kept over the rise, released at deselect
  task wr_close();
    hbdl_pins_t v;
    v = p;
    v.wr_n = 1'b1;
    put(v);
    v.cs_n = 1'b1;
    put(v);
  endtask : wr_close
  // address nibble, strobe low, data nibble on the same lines
  task ex_open(input logic [3:0] an, input logic [3:0] d);
    hbdl_pins_t v;
    v = p;
    v.nib = an;
    put(v);
    v.program_strobe = 1'b0;
    put(v);
    v.nib = d;
    put(v);
  endtask : ex_open
  task ex_close();
    hbdl_pins_t v;
    v = p;
    v.program_strobe = 1'b1;
    put(v);
  endtask : ex_close
endmodule : hbdl_host

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench import hbdl_pkg::*;;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  hbdl_pins_t  pins;
  hbdl_word_t  word_port;
  hbdl_nib_t   nib_port;
  hbdl_exp_t   exp_port;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          seed = 32'hf5ae;
  logic [11:0] held = 12'h000;
  logic [7:0]  lo;
  logic [7:0]  hi;
  logic [3:0]  ad;
  logic [3:0]  es;
  // clock
  always #5 mclk = ~mclk;
  hbdl_host host (.mclk(mclk), .pins(pins));
  hbdl_loader dut (.mclk(mclk), .nrst(nrst), .pins(pins), .word_port(word_port),
    .nib_port(nib_port), .exp_port(exp_port));
  // word port levels for a given access phase
  function automatic hbdl_word_t w_exp(input logic on, input logic st, input logic [11:0] w);
    return '{oe: on, cs_n: !st, wr_n: !st, data: w};
  endfunction : w_exp
  // page hit steers the byte half named by the low address bits
  function automatic hbdl_nib_t n_exp(input logic [3:0] a, input logic [7:0] d);
    if (a[3:2] != NIB_PAGE || a[1:0] == NIB_IDLE) return '{1'b0, 1'b1, NIB_IDLE, 4'h0};
    return '{1'b1, 1'b0, a[1:0], (a[1:0] == NIB_MID) ? d[7:4] : d[3:0]};
  endfunction : n_exp
  task chk(input logic [14:0] g, input logic [14:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, g, e);
    end
  endtask : chk
  task tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  // hang guard, run needs about 1250 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // reset, two-byte, nibble and expander traffic
  initial begin
    repeat (4) @(posedge mclk);
    #1;
    chk(15'(nib_port), 15'(n_exp(4'h0, 8'h00)));
    chk(15'(word_port), 15'(w_exp(1'b0, 1'b0, 12'h000)));
    chk(15'(exp_port), 15'({SEL_NONE, 4'h0}));
    @(posedge mclk);
    nrst <= 1'b1;
    // second byte alone joins the cleared first byte
    host.wr_open(ADDR_HI_BYTE, 8'h3c);
    chk(15'(word_port), 15'(w_exp(1'b1, 1'b1, 12'hc00)));
    host.wr_close();
    held = 12'hc00;
    for (int i = 0; i < 6; i++) begin
      lo = (i == 0) ? 8'hff : 8'($random(seed));
      hi = (i == 0) ? 8'hff : 8'($random(seed));
      host.wr_open(ADDR_LO_BYTE, lo);
      chk(15'(word_port), 15'(w_exp(1'b1, 1'b0, held)));
      chk(15'(nib_port), 15'(n_exp(ADDR_LO_BYTE, lo)));
      host.wr_close();
      host.wr_open(ADDR_HI_BYTE, hi);
      held = {hi[3:0], lo};
      chk(15'(word_port), 15'(w_exp(1'b1, 1'b1, held)));
      host.wr_close();
      chk(15'(word_port), 15'(w_exp(1'b0, 1'b0, held)));
    end
    for (int i = 0; i < 12; i++) begin
      ad = (i < 4) ? 4'(4 + i) : 4'($random(seed));
      lo = 8'($random(seed));
      host.wr_open(ad, lo);
      chk(15'(nib_port), 15'(n_exp(ad, lo)));
      chk(15'(word_port.oe), 15'(ad[3:1] == 3'h0));
      host.wr_close();
      chk(15'(nib_port), 15'(n_exp(4'h0, lo)));
    end
    for (int i = 0; i < 8; i++) begin
      ad = 4'($random(seed));
      lo = 8'($random(seed));
      es = SEL_NONE;
      if (i[1:0] == OP_WRITE) begin
        es[ad[1:0]] = 1'b0;
      end
      host.ex_open({i[1:0], ad[1:0]}, lo[3:0]);
      chk(15'(exp_port.sel_n), 15'(es));
      if (i[1:0] == OP_WRITE) begin
        chk(15'(exp_port.data), 15'(lo[3:0]));
      end
      host.ex_close();
      chk(15'(exp_port.sel_n), 15'(SEL_NONE));
    end
    // mid-run reset must drop the held byte left by the traffic above
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk(15'(word_port), 15'(w_exp(1'b0, 1'b0, 12'h000)));
    chk(15'(exp_port), 15'({SEL_NONE, 4'h0}));
    @(posedge mclk);
    nrst <= 1'b1;
    host.wr_open(ADDR_HI_BYTE, 8'ha5);
    chk(15'(word_port), 15'(w_exp(1'b1, 1'b1, 12'h500)));
    host.wr_close();
    tally_and_finish();
  end
endmodule : testbench
